// file: bench/gdfm_checker.sv
// Purpose: pin level checks on gdfm_top
// Assumes: deglitch and drive timeout of 4 cycles
// Notes: bound into every gdfm_top
`timescale 1ns/10ps
`default_nettype none
module gdfm_checker #(
  parameter int unsigned RST_PULSE_CYCLES = 10,
  parameter int unsigned SLEEP_CYCLES = 8,
  parameter int unsigned WAKE_CYCLES = 8
)(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic pin_config_in,
  input wire logic sense_overcurrent_in,
  input wire logic [5:0] gate_cmd_in,
  input wire logic [5:0] gate_level_in,
  input wire logic thermal_shutdown_in,
  input wire logic fault_out_n,
  input wire logic mosfet_enable_out,
  input wire logic charge_pump_enable_out,
  input wire logic regulators_enable_out,
  input wire logic ready_out
);
  localparam int W_LIM = WAKE_CYCLES + 3;
  localparam int S_LIM = RST_PULSE_CYCLES + SLEEP_CYCLES + 3;
  logic [15:0] low_cnt_r;
  // ------
  // enable low run length, saturating
  // ------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || enable_in)
    begin
      low_cnt_r <= 16'h0;
    end
    else if (low_cnt_r != 16'hffff)
    begin
      low_cnt_r <= low_cnt_r + 16'h1;
    end
  end
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sleep_quiet_a: assert property (!regulators_enable_out |-> !mosfet_enable_out && !charge_pump_enable_out && !ready_out)
    else $error("output on while regulators off");
  sleep_entry_a: assert property (int'(low_cnt_r) > S_LIM |-> !regulators_enable_out)
    else $error("no sleep after long enable low");
  wake_bound_a: assert property ($rose(regulators_enable_out) |-> ##[1:W_LIM] ready_out)
    else $error("wake too long");
  trans_fault_a: assert property (regulators_enable_out && !ready_out |-> !fault_out_n)
    else $error("fault pin released in transition");
  tsd_off_a: assert property (ready_out && thermal_shutdown_in |-> ##[1:2] (!mosfet_enable_out && !charge_pump_enable_out && !fault_out_n))
    else $error("overtemperature not acted on");
  tsd_resume_a: assert property ((ready_out && !thermal_shutdown_in) [*3] |-> charge_pump_enable_out)
    else $error("charge pump not resumed");
  sense_trip_a: assert property ((pin_config_in && ready_out && sense_overcurrent_in) [*5] |-> ##[0:3] (!fault_out_n && !mosfet_enable_out))
    else $error("sense trip missed");
  gate_trip_a: assert property ((pin_config_in && mosfet_enable_out && gate_cmd_in != gate_level_in) [*4] |-> ##[0:3] !fault_out_n)
    else $error("stuck gate missed");
  pulse_keeps_a: assert property (ready_out && !enable_in ##1 enable_in |=> ready_out [*3])
    else $error("clear pulse left operation");
  cover property ($fell(mosfet_enable_out) && ready_out);
  cover property ($rose(ready_out));
  cover property (ready_out && !enable_in ##1 enable_in);
endmodule : gdfm_checker
bind gdfm_top gdfm_checker #(
  .RST_PULSE_CYCLES(RST_PULSE_CYCLES),
  .SLEEP_CYCLES(SLEEP_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) u_gdfm_checker (.*);
`default_nettype wire

// file: bench/gdfm_ctrl_model.sv
// Purpose: controller model that drives the enable pin
// Assumes: tasks are entered right after a clock edge
// Notes: the caller picks the clear pulse low time
`timescale 1ns/10ps
`default_nettype none
module gdfm_ctrl_model (
  input wire logic clk_in,
  output logic enable_out
);
  initial enable_out = 1'b0;
  task automatic power(input logic on);
    @(posedge clk_in);
    enable_out <= on;
  endtask : power
  // a low time past the window starts a full shutdown instead
  task automatic clear_pulse(input int unsigned low_cycles);
    @(posedge clk_in);
    enable_out <= 1'b0;
    repeat (low_cycles) @(posedge clk_in);
    enable_out <= 1'b1;
  endtask : clear_pulse
endmodule : gdfm_ctrl_model
`default_nettype wire

// file: bench/test_gdfm_top.sv
// Purpose: self-checking bench for gdfm_top
// Assumes: short time parameters, fixed seed
// Notes: enable pin comes from the controller model
`timescale 1ns/10ps
`default_nettype none
module test_gdfm_top
  import gdfm_pkg::*;
();
  localparam int RETRY = 50;
  localparam int DEG_CYC = 4;
  localparam int DRV_CYC = 4;
  localparam int PULSE_CYC = 10;
  localparam int SLP_CYC = 8;
  localparam int WAKE_CYC = 8;
  logic clk, rst_n, pin_cfg, sense, tw, thermal_shutdown_flag, rd, wr, fault_n, mos, cp, regs, rdy, wait_o, en, uv;
  logic [5:0] gcmd, glev;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  int fail_count, n_compared;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  gdfm_ctrl_model i_ctl (.clk_in(clk), .enable_out(en));
  gdfm_top #(.DEGLITCH_CYCLES(DEG_CYC), .RETRY_CYCLES(RETRY), .DRIVE_CYCLES(DRV_CYC),
    .RST_PULSE_CYCLES(PULSE_CYC), .SLEEP_CYCLES(SLP_CYC), .WAKE_CYCLES(WAKE_CYC)) i_dut (
    .clk_sys_in(clk), .rst_n_in(rst_n), .enable_in(en), .supply_undervoltage_in(uv),
    .pin_config_in(pin_cfg), .sense_overcurrent_in(sense), .gate_cmd_in(gcmd), .gate_level_in(glev),
    .thermal_warning_in(tw), .thermal_shutdown_in(thermal_shutdown_flag), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .fault_out_n(fault_n), .mosfet_enable_out(mos), .charge_pump_enable_out(cp),
    .regulators_enable_out(regs), .ready_out(rdy));
  // ------
  // tasks
  // ------
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("waitrequest", 0, wait_o);
    @(posedge clk);
  endtask : bus
  task automatic wait_rdy;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk("ready", 1, rdy);
  endtask : wait_rdy
  task automatic trip(input int n);
    sense <= 1'b1;
    cyc(n);
    sense <= 1'b0;
    cyc(2);
  endtask : trip
  // {fault pin low, mosfets off} after a sense trip
  function automatic logic [1:0] sense_resp(input logic [1:0] mode, input logic dis);
    if (dis || mode == MODE_OFF)
    begin
      return 2'b00;
    end
    return (mode == MODE_REPORT) ? 2'b10 : 2'b11;
  endfunction : sense_resp
  initial
  begin
    #1000000;
    fail_count++;
    close_out();
  end
  initial
  begin
    logic [1:0] m, r;
    logic dis;
    logic [5:0] g;
    {rst_n, pin_cfg, sense, tw, thermal_shutdown_flag, rd, wr, uv} = 8'h0;
    {gcmd, glev, addr, wdata} = '0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(40998));
    cyc(5);
    chk("mos_rst", 0, mos);
    rst_n <= 1'b1;
    i_ctl.power(1'b1);
    cyc(4);
    chk("wake_fault", 0, fault_n);
    wait_rdy();
    cyc(2);
    chk("oper_cp", 1, cp);
    bus(1'b0, ADDR_CONTROL, 0);
    chk("ctrl_rst", CONTROL_RESET, q);
    $display("test wake done");
    for (int i = 0; i < 5; i++)
    begin
      m = i[1:0];
      dis = (i == 4);
      r = sense_resp(m, dis);
      bus(1'b1, ADDR_CONTROL, {28'h0, dis, m, 1'b0});
      trip(3);
      chk("glitch", 1, fault_n);
      trip(5 + $urandom_range(4));
      chk("trip_fault", !r[1], fault_n);
      chk("trip_mos", !r[0], mos);
      bus(1'b0, ADDR_STATUS, 0);
      chk("summary", r[1], q[ST_SUMMARY]);
      chk("sense_flag", r[1], q[ST_SENSE]);
      if (m == MODE_RETRY)
      begin
        cyc(RETRY);
      end
      chk("held", !(r[1] && m != MODE_RETRY), fault_n);
      bus(1'b1, ADDR_CONTROL, {28'h0, dis, m, 1'b1});
      cyc(2);
      chk("cleared", 1, fault_n);
      chk("running", 1, mos);
    end
    $display("test sense done");
    bus(1'b1, ADDR_CONTROL, 32'h1 << CT_GDF_DIS);
    glev <= 6'h3f;
    cyc(8);
    chk("gate_dis", 1, fault_n);
    glev <= gcmd;
    bus(1'b1, ADDR_CONTROL, {29'h0, MODE_REPORT, 1'b0});
    trip(6);
    chk("report", 0, fault_n);
    i_ctl.clear_pulse(4);
    cyc(4);
    chk("pulse_clr", 1, fault_n);
    bus(1'b0, ADDR_CONTROL, 0);
    chk("ctrl_kept", {29'h0, MODE_REPORT, 1'b0}, q);
    $display("test pulse done");
    tw <= 1'b1;
    cyc(3);
    chk("tw_quiet", 1, fault_n);
    bus(1'b1, ADDR_CONTROL, 32'h1 << CT_TW_REP);
    cyc(2);
    chk("tw_rep", 0, fault_n);
    tw <= 1'b0;
    cyc(3);
    chk("tw_gone", 1, fault_n);
    thermal_shutdown_flag <= 1'b1;
    cyc(3);
    chk("tsd_cp", 0, cp);
    thermal_shutdown_flag <= 1'b0;
    cyc(3);
    chk("tsd_back", 1, mos);
    bus(1'b0, ADDR_STATUS, 0);
    chk("tsd_flag", 1, q[ST_TSD]);
    bus(1'b1, ADDR_CONTROL, 32'h1);
    bus(1'b0, ADDR_STATUS, 0);
    chk("tsd_clr", 0, q[ST_TSD]);
    $display("test thermal done");
    // disables written here must be ignored on the fixed variant
    pin_cfg <= 1'b1;
    bus(1'b1, ADDR_CONTROL, 32'h1e);
    trip(6);
    chk("pin_trip", 0, mos);
    cyc(RETRY);
    chk("pin_retry", 1, fault_n);
    g = 6'($urandom);
    gcmd <= g;
    glev <= g ^ 6'h08;
    cyc(8);
    chk("gdf", 0, fault_n);
    bus(1'b0, ADDR_GATE_STATUS, 0);
    chk("gate_flag", 32'h08, q);
    glev <= g;
    cyc(2);
    chk("gdf_held", 0, fault_n);
    bus(1'b1, ADDR_CONTROL, 32'h1);
    cyc(2);
    chk("gdf_clr", 1, mos);
    $display("test pin variant done");
    uv <= 1'b1;
    cyc(3);
    chk("uv_ready", 0, rdy);
    chk("uv_fault", 0, fault_n);
    uv <= 1'b0;
    wait_rdy();
    chk("uv_back", 1, fault_n);
    $display("test undervoltage done");
    i_ctl.power(1'b0);
    cyc(24);
    chk("sleep", 0, regs);
    i_ctl.power(1'b1);
    wait_rdy();
    $display("test sleep done");
    close_out();
  end
endmodule : test_gdfm_top
`default_nettype wire

// file: hdl/gdfm_pkg.sv
// Purpose: constants for the gate driver fault manager
// Assumes: 50 MHz system clock
// Notes: register offsets are word aligned byte addresses
package gdfm_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // ----------------------------------------
  // times in their own units
  // ----------------------------------------
  localparam int unsigned DEGLITCH_NS = 4000;
  localparam int unsigned RETRY_US = 4000;
  localparam int unsigned DRIVE_TIMEOUT_NS = 4000;
  localparam int unsigned RST_PULSE_US = 40;
  localparam int unsigned SLEEP_DELAY_US = 100;
  localparam int unsigned WAKE_TIME_US = 1000;
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RETRY_CYC = RETRY_US * (CLK_HZ / 1000000);
  localparam int unsigned DRIVE_TIMEOUT_CYC = (DRIVE_TIMEOUT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * (CLK_HZ / 1000000);
  localparam int unsigned SLEEP_DELAY_CYC = SLEEP_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned WAKE_TIME_CYC = WAKE_TIME_US * (CLK_HZ / 1000000);
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_GATE_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // status bit positions
  localparam int unsigned ST_SUMMARY = 0;
  localparam int unsigned ST_SENSE = 1;
  localparam int unsigned ST_GDF = 2;
  localparam int unsigned ST_TSD = 3;
  localparam int unsigned ST_TW = 4;
  localparam int unsigned ST_MOS_ON = 5;
  localparam int unsigned ST_CP_ON = 6;
  localparam int unsigned ST_OPER = 7;
  // control bit positions
  localparam int unsigned CT_CLEAR = 0;
  localparam int unsigned CT_MODE_LO = 1;
  localparam int unsigned CT_SENSE_DIS = 3;
  localparam int unsigned CT_GDF_DIS = 4;
  localparam int unsigned CT_TW_REP = 5;
  // response modes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  typedef enum logic [3:0] {
    GDFM_SLEEP = 4'b0001,
    GDFM_WAKE = 4'b0010,
    GDFM_OPER = 4'b0100,
    GDFM_GOSLEEP = 4'b1000
  } gdfm_pwr_t;
endpackage : gdfm_pkg

// file: hdl/gdfm_top.sv
// Purpose: fault handling and power state control of a three-phase gate driver
// Assumes: comparator flags already synchronous to clk_sys_in
// Notes: pin_config_in high selects the fixed-response variant
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gdfm_top
  import gdfm_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned DRIVE_CYCLES = DRIVE_TIMEOUT_CYC,
  parameter int unsigned RST_PULSE_CYCLES = RST_PULSE_CYC,
  parameter int unsigned SLEEP_CYCLES = SLEEP_DELAY_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_TIME_CYC
)(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic supply_undervoltage_in,
  input wire logic pin_config_in,
  input wire logic sense_overcurrent_in,
  input wire logic [5:0] gate_cmd_in,
  input wire logic [5:0] gate_level_in,
  input wire logic thermal_warning_in,
  input wire logic thermal_shutdown_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic fault_out_n,
  output logic mosfet_enable_out,
  output logic charge_pump_enable_out,
  output logic regulators_enable_out,
  output logic ready_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] cnt_step(input logic [31:0] c, input logic run);
    cnt_step = run ? c + 32'h1 : 32'h0;
  endfunction : cnt_step

  gdfm_pwr_t pwr_r;
  logic [31:0] pwr_cnt_r;
  logic [31:0] low_cnt_r;
  logic en_d_r;
  logic pulse_clear_r;
  logic [31:0] ctrl_r;
  logic [31:0] deg_cnt_r;
  logic [31:0] retry_cnt_r;
  logic [31:0] drv_cnt_r [6];
  logic sense_flag_r;
  logic sense_shut_r;
  logic gdf_flag_r;
  logic [5:0] vgs_flags_r;
  logic tsd_flag_r;
  logic clear_bit_r;
  logic ack_r;
  logic [1:0] mode;
  logic sense_off;
  logic sense_trip;
  logic [5:0] gate_stuck;
  logic gdf_on;
  logic clear_any;
  logic oper;
  logic summary;

  assign oper = (pwr_r == GDFM_OPER);
  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  always_comb
  begin
    if (pin_config_in)
    begin
      mode = MODE_RETRY;
      sense_off = 1'b0;
      gdf_on = 1'b1;
    end
    else
    begin
      mode = ctrl_r[CT_MODE_LO +: 2];
      sense_off = (mode == MODE_OFF) || ctrl_r[CT_SENSE_DIS];
      gdf_on = !ctrl_r[CT_GDF_DIS];
    end
  end

  assign sense_trip = oper && !sense_off && sense_overcurrent_in && (deg_cnt_r >= DEGLITCH_CYCLES);
  assign clear_any = clear_bit_r || pulse_clear_r;

  // ----------------------------------------
  // power state
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pwr_r <= GDFM_SLEEP;
      pwr_cnt_r <= 32'h0;
    end
    else
    begin
      case (pwr_r)
        GDFM_SLEEP:
        begin
          pwr_cnt_r <= 32'h0;
          if (enable_in)
            pwr_r <= GDFM_WAKE;
        end
        GDFM_WAKE:
        begin
          pwr_cnt_r <= pwr_cnt_r + 32'h1;
          if (!enable_in)
          begin
            pwr_r <= GDFM_SLEEP;
          end
          else if (pwr_cnt_r + 32'h1 >= WAKE_CYCLES && !supply_undervoltage_in)
          begin
            pwr_r <= GDFM_OPER;
            pwr_cnt_r <= 32'h0;
          end
        end
        GDFM_OPER:
        begin
          pwr_cnt_r <= 32'h0;
          if (supply_undervoltage_in)
            pwr_r <= GDFM_WAKE;
          else if (!enable_in && low_cnt_r + 32'h1 >= RST_PULSE_CYCLES)
            pwr_r <= GDFM_GOSLEEP;
        end
        GDFM_GOSLEEP:
        begin
          pwr_cnt_r <= pwr_cnt_r + 32'h1;
          if (enable_in)
          begin
            pwr_r <= GDFM_WAKE;
            pwr_cnt_r <= 32'h0;
          end
          else if (pwr_cnt_r + 32'h1 >= SLEEP_CYCLES)
            pwr_r <= GDFM_SLEEP;
        end
        default:
          pwr_r <= GDFM_SLEEP;
      endcase
    end
  end

  // ----------------------------------------
  // enable reset pulse
  // ----------------------------------------
  // a short low in operating mode clears faults; longer lows go to sleep
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      en_d_r <= 1'b0;
      low_cnt_r <= 32'h0;
      pulse_clear_r <= 1'b0;
    end
    else
    begin
      en_d_r <= enable_in;
      low_cnt_r <= (oper && !enable_in) ? low_cnt_r + 32'h1 : 32'h0;
      pulse_clear_r <= oper && enable_in && !en_d_r && (low_cnt_r != 32'h0) &&
                       (low_cnt_r < RST_PULSE_CYCLES);
    end
  end

  // ----------------------------------------
  // sense overcurrent
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      deg_cnt_r <= 32'h0;
    else if (deg_cnt_r >= DEGLITCH_CYCLES)
      deg_cnt_r <= sense_overcurrent_in ? deg_cnt_r : 32'h0;
    else
      deg_cnt_r <= cnt_step(deg_cnt_r, oper && sense_overcurrent_in);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !oper)
    begin
      sense_flag_r <= 1'b0;
      sense_shut_r <= 1'b0;
      retry_cnt_r <= 32'h0;
    end
    else if (sense_trip && !sense_flag_r)
    begin
      sense_flag_r <= 1'b1;
      sense_shut_r <= (mode != MODE_REPORT);
      retry_cnt_r <= 32'h0;
    end
    else if (sense_flag_r && mode == MODE_RETRY)
    begin
      retry_cnt_r <= retry_cnt_r + 32'h1;
      if (retry_cnt_r + 32'h1 >= RETRY_CYCLES)
      begin
        sense_flag_r <= 1'b0;
        sense_shut_r <= 1'b0;
      end
    end
    else if (sense_flag_r && clear_any && !sense_overcurrent_in)
    begin
      sense_flag_r <= 1'b0;
      sense_shut_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // gate drive fault, one timer per gate
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_drv
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
          drv_cnt_r[gi] <= 32'h0;
        else if (drv_cnt_r[gi] >= DRIVE_CYCLES)
          drv_cnt_r[gi] <= (gate_cmd_in[gi] != gate_level_in[gi]) ? drv_cnt_r[gi] : 32'h0;
        else
          drv_cnt_r[gi] <= cnt_step(drv_cnt_r[gi], oper && mosfet_enable_out &&
                                    (gate_cmd_in[gi] != gate_level_in[gi]));
      end
      assign gate_stuck[gi] = drv_cnt_r[gi] >= DRIVE_CYCLES;
    end
  endgenerate

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !oper || !gdf_on)
    begin
      gdf_flag_r <= 1'b0;
      vgs_flags_r <= 6'h0;
    end
    else if (|gate_stuck)
    begin
      gdf_flag_r <= 1'b1;
      vgs_flags_r <= vgs_flags_r | gate_stuck;
    end
    else if (clear_any)
    begin
      gdf_flag_r <= 1'b0;
      vgs_flags_r <= 6'h0;
    end
  end

  // ----------------------------------------
  // thermal shutdown flag
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      tsd_flag_r <= 1'b0;
    else if (thermal_shutdown_in)
      tsd_flag_r <= 1'b1;
    else if (clear_any)
      tsd_flag_r <= 1'b0;
  end

  // summary: or of fault flags, also raised while regulators move
  assign summary = sense_flag_r || gdf_flag_r || tsd_flag_r || thermal_shutdown_in ||
                   (thermal_warning_in && ctrl_r[CT_TW_REP]) ||
                   (pwr_r == GDFM_WAKE) || (pwr_r == GDFM_GOSLEEP);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      fault_out_n <= 1'b1;
      mosfet_enable_out <= 1'b0;
      charge_pump_enable_out <= 1'b0;
      regulators_enable_out <= 1'b0;
      ready_out <= 1'b0;
    end
    else
    begin
      fault_out_n <= !summary || (pwr_r == GDFM_SLEEP);
      mosfet_enable_out <= oper && !sense_shut_r && !gdf_flag_r && !thermal_shutdown_in;
      charge_pump_enable_out <= oper && !thermal_shutdown_in;
      regulators_enable_out <= (pwr_r != GDFM_SLEEP);
      ready_out <= oper;
    end
  end

  // ----------------------------------------
  // avalon slave, one wait cycle per access
  // ----------------------------------------
  // waitrequest is a registered inverse of the ack decision, so the pin comes from a flop
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ack_r <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      ack_r <= (avs_read_in || avs_write_in) && !ack_r;
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_r);
    end
  end

  // clear bit is a self-clearing strobe; settings survive pulses
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_r <= CONTROL_RESET;
      clear_bit_r <= 1'b0;
    end
    else
    begin
      clear_bit_r <= 1'b0;
      if (avs_write_in && ack_r && avs_address_in == ADDR_CONTROL && oper)
      begin
        ctrl_r <= {26'h0, avs_writedata_in[5:1], 1'b0};
        clear_bit_r <= avs_writedata_in[CT_CLEAR];
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      avs_readdata_out <= 32'h0;
    else if (avs_read_in && !ack_r)
    begin
      if (avs_address_in == ADDR_STATUS)
        avs_readdata_out <= {24'h0, oper, charge_pump_enable_out, mosfet_enable_out,
                             thermal_warning_in, tsd_flag_r, gdf_flag_r, sense_flag_r, !fault_out_n};
      else if (avs_address_in == ADDR_GATE_STATUS)
        avs_readdata_out <= {26'h0, vgs_flags_r};
      else if (avs_address_in == ADDR_CONTROL)
        avs_readdata_out <= ctrl_r;
      else
        avs_readdata_out <= 32'h0;
    end
  end
endmodule : gdfm_top
`default_nettype wire
